// ===== design/opllcc_consts.vh
// Purpose: shared offsets, field positions, reset values and encodings
// Assumes: 8-bit register file on the control port
// Notes:   included by the top-level opllcc design file only
`ifndef OPLLCC_CONSTS_VH
`define OPLLCC_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define OPLLCC_ADDR_FRAC_LOW    7'h03
`define OPLLCC_ADDR_FRAC_MID    7'h04
`define OPLLCC_ADDR_FRAC_HIGH   7'h05
`define OPLLCC_ADDR_INT_PREDIV  7'h06
`define OPLLCC_ADDR_MODE_POST   7'h07
`define OPLLCC_ADDR_POWER_DOWN  7'h1e

// ****************************************
// reset values
// ****************************************
`define OPLLCC_RST_FRAC_LOW     8'h21
`define OPLLCC_RST_FRAC_MID     8'hfd
`define OPLLCC_RST_FRAC_HIGH    8'h36
`define OPLLCC_RST_INT_PREDIV   8'h07
`define OPLLCC_RST_MODE_POST    8'h06
`define OPLLCC_RST_POWER_DOWN   8'h0f

// ****************************************
// field positions
// ****************************************
`define OPLLCC_BIT_OSC_OFF      3
`define OPLLCC_BIT_SYNTH_OFF    0
`define OPLLCC_BIT_HALVER       4
`define OPLLCC_BIT_FRAC_SEL     2
`define OPLLCC_INT_MSB          3
`define OPLLCC_FRACH_MSB        5
`define OPLLCC_POST_MSB         1

// ****************************************
// automatic mode defaults (about 24 MHz from a 12 MHz reference)
// ****************************************
`define OPLLCC_AUTO_DEF_INT     4'h8
`define OPLLCC_AUTO_DEF_FRAC    22'h000000
`define OPLLCC_AUTO_DEF_POST    2'h1

`endif

// ===== design/opllcc_refgen.v
// Purpose: oscillator reference clock and input halver
// Assumes: crystal input pin is asynchronous to CLOCK
// Notes:   ticks are one-cycle pulses; osc_tick on each rising oscillator edge, ref_tick on every second one when halving
`timescale 1ns/10ps
`default_nettype none

module opllcc_refgen (
  input  wire clk,          // system clock
  input  wire rst,          // synchronous reset, high
  input  wire pin_in,       // crystal input pin
  input  wire osc_on,       // oscillator powered
  input  wire halve,        // divide reference by two
  output reg  osc_level,    // gated oscillator level
  output reg  osc_tick,     // oscillator rising edge pulse
  output reg  ref_tick      // post-halver reference pulse
);

  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  reg half_reg;

  // ****************************************
  // synchroniser and edge detect
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
      half_reg  <= 1'b0;
      osc_level <= 1'b0;
      osc_tick  <= 1'b0;
      ref_tick  <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
      // [R3] no clock while off
      osc_level <= osc_on & sync2_reg;
      osc_tick  <= osc_on & sync2_reg & ~prev_reg;
      ref_tick  <= 1'b0;
      if (osc_on & sync2_reg & ~prev_reg) begin
        half_reg <= ~half_reg;
        // [R19] pass or halve
        ref_tick <= halve ? half_reg : 1'b1;
      end
    end
  end

endmodule // opllcc_refgen

`default_nettype wire

// ===== design/opllcc_nco.v
// Purpose: behavioural fractional-N synthesiser with post divider
// Assumes: post-divided toggle rate stays below CLOCK rate
// Notes:   toggles per reference edge = 2*R / divisor
`timescale 1ns/10ps
`default_nettype none

module opllcc_nco (
  input  wire        clk,        // system clock
  input  wire        rst,        // synchronous reset, high
  input  wire        enable,     // synthesiser running
  input  wire        ref_tick,   // reference edge pulse
  input  wire [25:0] mult,       // ratio, 4 integer + 22 fraction bits
  input  wire [1:0]  post_sel,   // divisor 2, 4, 8 or 16
  output reg         synth_out   // post-divided clock level
);

  reg  [21:0] frac_reg;
  reg  [5:0]  pend_reg;
  wire [25:0] step;
  wire [26:0] sum;
  wire [5:0]  pend_sum;
  wire        busy;

  // [R18] post divider as a shift
  assign step     = mult >> post_sel;
  // [R14] integer plus fraction over 2^22
  assign sum      = {5'h00, frac_reg} + {1'b0, step};
  assign busy     = (pend_reg != 6'h00);
  assign pend_sum = pend_reg + {1'b0, sum[26:22]};

  // ****************************************
  // phase accumulator and toggle queue
  // ****************************************
  always @(posedge clk) begin
    if (rst | ~enable) begin
      frac_reg  <= 22'h000000;
      pend_reg  <= 6'h00;
      synth_out <= 1'b0;
    end else begin
      if (busy) begin
        synth_out <= ~synth_out;
      end
      // [R15] output tracks post-halver input
      if (ref_tick) begin
        frac_reg <= sum[21:0];
        pend_reg <= pend_sum - {5'h00, busy};
      end else if (busy) begin
        pend_reg <= pend_reg - 6'h01;
      end
    end
  end

endmodule // opllcc_nco

`default_nettype wire

// ===== design/opllcc_top.v
// Purpose: oscillator and synthesiser clock control with register file
// Assumes: control port delivers decoded register accesses
// Notes:   receiver drives ratio while enabled
// Functional notes
// [R1] synthesiser reference comes only from the oscillator clock
// [R2] oscillator selectable as master pin and auxiliary output source
// [R3] power bit 3 resets high; oscillator clock absent while off
// [R4] power bit 0 resets high; writing zero powers synthesiser up
// [R5] receiver enabled means automatic mode, receiver steers the ratio
// [R6] derived clocks follow stream rate, keep toggling through relock
// [R7] stream stops: integer and fraction frozen at last values
// [R8] no stream since reset: automatic mode gives about 24 MHz
// [R9] receiver disabled: programmed fields fully set the clocks
// [R10] 22-bit fraction spread over three registers
// [R11] fraction bytes reset to 21h, fdh, 36h
// [R12] integer field bits 3:0 of 06h, reset 0111
// [R13] software keeps integer between 5 and 13
// [R14] ratio equals integer plus fraction over 2^22
// [R15] ratio is output over post-halver input frequency
// [R16] software truncates ratio parts when computing fields
// [R17] software aims output between 90 and 100 MHz
// [R18] post divider scales output before all clock consumers
// [R19] bit 4 of 06h halves reference, reset zero
// [R20] bits 1:0 of 07h select post divider, reset 10
// [R21] automatic mode sets post divider field itself
// [R22] software programs receiver-specific ratio values
// [R23] bit 2 of 07h fractional select, default one
`timescale 1ns/10ps
`default_nettype none
`include "opllcc_consts.vh"

module opllcc_top (
  input  wire        CLOCK,           // 200 MHz system clock
  input  wire        RESET,           // synchronous reset, high
  input  wire        CRYSTAL_INPUT_PIN, // oscillator input
  input  wire [6:0]  REG_ADDR,        // register index
  input  wire [7:0]  REG_WDATA,       // write data
  input  wire        REG_WE,          // write strobe
  input  wire        REG_RE,          // read strobe
  input  wire        RX_ENABLE,       // receiver enabled
  input  wire        RX_STREAM,       // incoming stream present
  input  wire [3:0]  RX_INT,          // receiver integer request
  input  wire [21:0] RX_FRAC,         // receiver fraction request
  input  wire [1:0]  RX_POST,         // receiver post divider request
  input  wire        MASTER_IS_OUT,   // master pin configured as output
  input  wire        MASTER_SRC_OSC,  // master pin from oscillator
  input  wire        AUX_ENABLE,      // auxiliary output enabled
  input  wire        AUX_SRC_OSC,     // auxiliary output from oscillator
  output reg  [7:0]  REG_RDATA,       // read data
  output reg         REG_RVALID,      // read data valid pulse
  output reg         MASTER_CLK_O,    // master pin drive level
  output reg         MASTER_CLK_OE_N, // master pin enable, low drives
  output reg         AUX_CLOCK_PIN,   // auxiliary clock output
  output reg         TX_CLOCK,        // transmitter clock
  output reg         OSC_REF_CLOCK,   // oscillator clock level
  output reg         AUTO_MODE,       // automatic mode active
  output reg         SYNTH_RUNNING    // synthesiser active
);

  // ****************************************
  // registers
  // ****************************************
  reg  [7:0]  frac_low_reg;
  reg  [7:0]  frac_mid_reg;
  reg  [7:0]  frac_high_reg;
  reg  [7:0]  int_prediv_reg;
  reg  [7:0]  mode_post_reg;
  reg  [7:0]  power_down_reg;
  reg  [3:0]  auto_int_reg;
  reg  [21:0] auto_frac_reg;
  reg  [1:0]  auto_post_reg;
  reg  [7:0]  rdata_next;

  wire        osc_on;
  wire        synth_on;
  wire        auto_mode;
  wire        osc_level;
  wire        ref_tick;
  wire        synth_level;
  wire [21:0] man_frac;
  wire [25:0] mult;
  wire [1:0]  post_sel;
  wire        sel_frac_low;
  wire        sel_frac_mid;
  wire        sel_frac_high;
  wire        sel_int_prediv;
  wire        sel_mode_post;
  wire        sel_power_down;

  // ****************************************
  // helper functions
  // ****************************************
  // address compare for one register index
  function addr_hit;
    input [6:0] addr;
    input [6:0] index;
    begin
      addr_hit = (addr == index);
    end
  endfunction

  // gated clock source pick for an output pin
  function pin_source;
    input enable;
    input use_osc;
    input osc_clk;
    input synth_clk;
    begin
      pin_source = enable & (use_osc ? osc_clk : synth_clk);
    end
  endfunction

  // ****************************************
  // register select
  // ****************************************
  assign sel_frac_low   = addr_hit(REG_ADDR, `OPLLCC_ADDR_FRAC_LOW);
  assign sel_frac_mid   = addr_hit(REG_ADDR, `OPLLCC_ADDR_FRAC_MID);
  assign sel_frac_high  = addr_hit(REG_ADDR, `OPLLCC_ADDR_FRAC_HIGH);
  assign sel_int_prediv = addr_hit(REG_ADDR, `OPLLCC_ADDR_INT_PREDIV);
  assign sel_mode_post  = addr_hit(REG_ADDR, `OPLLCC_ADDR_MODE_POST);
  assign sel_power_down = addr_hit(REG_ADDR, `OPLLCC_ADDR_POWER_DOWN);

  // [R3] oscillator power bit
  assign osc_on    = ~power_down_reg[`OPLLCC_BIT_OSC_OFF];
  // [R4] synthesiser needs both power bits
  assign synth_on  = ~power_down_reg[`OPLLCC_BIT_SYNTH_OFF] & osc_on;
  // [R5] receiver selects automatic mode
  assign auto_mode = RX_ENABLE;
  // [R10] fraction assembled from three bytes
  assign man_frac  = {frac_high_reg[`OPLLCC_FRACH_MSB:0], frac_mid_reg, frac_low_reg};

  // [R9] manual fields; [R23] integer mode drops fraction
  // [R6] automatic ratio follows receiver
  assign mult = auto_mode ? {auto_int_reg, auto_frac_reg} :
                {int_prediv_reg[`OPLLCC_INT_MSB:0],
                 mode_post_reg[`OPLLCC_BIT_FRAC_SEL] ? man_frac : 22'h000000};
  assign post_sel = mode_post_reg[`OPLLCC_POST_MSB:0];

  // ****************************************
  // register writes
  // ****************************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      // [R11] [R12] [R19] [R20] [R23] reset values
      frac_low_reg   <= `OPLLCC_RST_FRAC_LOW;
      frac_mid_reg   <= `OPLLCC_RST_FRAC_MID;
      frac_high_reg  <= `OPLLCC_RST_FRAC_HIGH;
      int_prediv_reg <= `OPLLCC_RST_INT_PREDIV;
      mode_post_reg  <= `OPLLCC_RST_MODE_POST;
      // [R3] [R4] powered down at reset
      power_down_reg <= `OPLLCC_RST_POWER_DOWN;
    end else begin
      if (REG_WE) begin
        if (sel_frac_low) begin
          frac_low_reg <= REG_WDATA;
        end else if (sel_frac_mid) begin
          frac_mid_reg <= REG_WDATA;
        end else if (sel_frac_high) begin
          frac_high_reg <= REG_WDATA;
        end else if (sel_int_prediv) begin
          int_prediv_reg <= REG_WDATA;
        end else if (sel_mode_post) begin
          mode_post_reg[7:2] <= REG_WDATA[7:2];
          if (!auto_mode) begin
            mode_post_reg[1:0] <= REG_WDATA[1:0];
          end
        end else if (sel_power_down) begin
          power_down_reg <= REG_WDATA;
        end
      end
      // [R21] device owns post divider in automatic mode
      if (auto_mode) begin
        mode_post_reg[1:0] <= auto_post_reg;
      end
    end
  end

  // ****************************************
  // automatic mode ratio hold
  // ****************************************
  // [R7] ratio frozen while stream absent
  always @(posedge CLOCK) begin
    if (RESET) begin
      // [R8] default about 24 MHz
      auto_int_reg  <= `OPLLCC_AUTO_DEF_INT;
      auto_frac_reg <= `OPLLCC_AUTO_DEF_FRAC;
      auto_post_reg <= `OPLLCC_AUTO_DEF_POST;
    end else if (auto_mode & RX_STREAM) begin
      auto_int_reg  <= RX_INT;
      auto_frac_reg <= RX_FRAC;
      auto_post_reg <= RX_POST;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always @* begin
    rdata_next = 8'h00;
    if (sel_frac_low) begin
      rdata_next = frac_low_reg;
    end else if (sel_frac_mid) begin
      rdata_next = frac_mid_reg;
    end else if (sel_frac_high) begin
      rdata_next = frac_high_reg;
    end else if (sel_int_prediv) begin
      rdata_next = int_prediv_reg;
    end else if (sel_mode_post) begin
      rdata_next = mode_post_reg;
    end else if (sel_power_down) begin
      rdata_next = power_down_reg;
    end
  end

  // ****************************************
  // clock generation
  // ****************************************
  // [R1] reference only from oscillator
  opllcc_refgen u_refgen (
    .clk       (CLOCK),
    .rst       (RESET),
    .pin_in    (CRYSTAL_INPUT_PIN),
    .osc_on    (osc_on),
    .halve     (int_prediv_reg[`OPLLCC_BIT_HALVER]),
    .osc_level (osc_level),
    .osc_tick  (),
    .ref_tick  (ref_tick)
  );

  opllcc_nco u_nco (
    .clk       (CLOCK),
    .rst       (RESET),
    .enable    (synth_on),
    .ref_tick  (ref_tick),
    .mult      (mult),
    .post_sel  (post_sel),
    .synth_out (synth_level)
  );

  // ****************************************
  // read port
  // ****************************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RE;
      if (REG_RE) begin
        REG_RDATA <= rdata_next;
      end
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      MASTER_CLK_O    <= 1'b0;
      MASTER_CLK_OE_N <= 1'b1;
      AUX_CLOCK_PIN   <= 1'b0;
      TX_CLOCK        <= 1'b0;
      OSC_REF_CLOCK   <= 1'b0;
      AUTO_MODE       <= 1'b0;
      SYNTH_RUNNING   <= 1'b0;
    end else begin
      // [R2] oscillator or synthesiser as source
      MASTER_CLK_O    <= pin_source(MASTER_IS_OUT, MASTER_SRC_OSC, osc_level, synth_level);
      MASTER_CLK_OE_N <= ~MASTER_IS_OUT;
      AUX_CLOCK_PIN   <= pin_source(AUX_ENABLE, AUX_SRC_OSC, osc_level, synth_level);
      // [R18] divided synthesiser clock to transmitter
      TX_CLOCK        <= synth_level;
      // [R3] gated oscillator level
      OSC_REF_CLOCK   <= osc_level;
      AUTO_MODE       <= auto_mode;
      SYNTH_RUNNING   <= synth_on;
    end
  end

endmodule // opllcc_top

`default_nettype wire

// ===== tb/opllcc_monitor.sv
// Purpose: port checker for opllcc_top
// Assumes: power bits mirrored from decoded writes
// Notes:   bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module opllcc_monitor (
  input wire logic       CLOCK,           // clock
  input wire logic       RESET,           // reset
  input wire logic [6:0] REG_ADDR,        // index
  input wire logic [7:0] REG_WDATA,       // write data
  input wire logic       REG_WE,          // write
  input wire logic       REG_RE,          // read
  input wire logic       RX_ENABLE,       // receiver on
  input wire logic       MASTER_IS_OUT,   // master out
  input wire logic       AUX_ENABLE,      // aux on
  input wire logic [7:0] REG_RDATA,       // read data
  input wire logic       REG_RVALID,      // read valid
  input wire logic       MASTER_CLK_O,    // master level
  input wire logic       MASTER_CLK_OE_N, // master enable
  input wire logic       AUX_CLOCK_PIN,   // aux level
  input wire logic       OSC_REF_CLOCK,   // osc level
  input wire logic       AUTO_MODE,       // auto mode
  input wire logic       SYNTH_RUNNING    // synth on
);
  // ****************************************
  // power bit mirror
  // ****************************************
  reg       osc_off_reg;
  reg       syn_off_reg;
  reg [3:0] off_cnt_reg;
  always @(posedge CLOCK) begin
    if (RESET) begin
      osc_off_reg <= 1'b1;
      syn_off_reg <= 1'b1;
      off_cnt_reg <= 4'h0;
    end else begin
      if (REG_WE && REG_ADDR == 7'h1e) begin
        osc_off_reg <= REG_WDATA[3];
        syn_off_reg <= REG_WDATA[0];
      end
      if (!osc_off_reg) off_cnt_reg <= 4'h0;
      else if (off_cnt_reg != 4'hf) off_cnt_reg <= off_cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  chk_osc_quiet: assert property (off_cnt_reg == 4'hf |-> !OSC_REF_CLOCK)
    else $error("oscillator clock while off");
  chk_synth_run: assert property (!$past(RESET) |-> SYNTH_RUNNING == $past(!syn_off_reg && !osc_off_reg))
    else $error("synth running flag wrong");
  chk_auto_mode: assert property (!$past(RESET) |-> AUTO_MODE == $past(RX_ENABLE))
    else $error("auto mode flag wrong");
  chk_read_valid: assert property (!$past(RESET) |-> REG_RVALID == $past(REG_RE))
    else $error("read valid wrong");
  chk_master_oe: assert property (!$past(RESET) |-> MASTER_CLK_OE_N == !$past(MASTER_IS_OUT))
    else $error("master enable wrong");
  chk_master_low: assert property (!MASTER_IS_OUT [*3] |-> !MASTER_CLK_O)
    else $error("master pin active while input");
  chk_aux_low: assert property (!AUX_ENABLE [*3] |-> !AUX_CLOCK_PIN)
    else $error("aux pin active while off");
  chk_power_read: assert property (REG_RE && REG_ADDR == 7'h1e |=> REG_RDATA[3] == $past(osc_off_reg) && REG_RDATA[0] == $past(syn_off_reg))
    else $error("power bits read wrong");
endmodule // opllcc_monitor
bind opllcc_top opllcc_monitor mon_u (.CLOCK(CLOCK), .RESET(RESET), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .RX_ENABLE(RX_ENABLE),
  .MASTER_IS_OUT(MASTER_IS_OUT), .AUX_ENABLE(AUX_ENABLE), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .MASTER_CLK_O(MASTER_CLK_O), .MASTER_CLK_OE_N(MASTER_CLK_OE_N),
  .AUX_CLOCK_PIN(AUX_CLOCK_PIN), .OSC_REF_CLOCK(OSC_REF_CLOCK), .AUTO_MODE(AUTO_MODE),
  .SYNTH_RUNNING(SYNTH_RUNNING));
`default_nettype wire

// ===== tb/opllcc_top_tb.sv
// Purpose: self-checking bench for opllcc_top
// Assumes: crystal at 16 cycles a period
// Notes:   rates judged by edge counts, two edges slack
`timescale 1ns/10ps
`default_nettype none
module opllcc_top_tb;
  // ****************************************
  // stimulus and hookup
  // ****************************************
  logic        CLOCK = 1'b0, RESET = 1'b1, CRYSTAL_INPUT_PIN = 1'b0;
  logic [6:0]  REG_ADDR = 7'h00;
  logic [7:0]  REG_WDATA = 8'h00;
  logic        REG_WE = 1'b0, REG_RE = 1'b0, RX_ENABLE = 1'b0, RX_STREAM = 1'b0;
  logic [3:0]  RX_INT = 4'h8;
  logic [21:0] RX_FRAC = 22'h000000;
  logic [1:0]  RX_POST = 2'h3;
  logic        MASTER_IS_OUT = 1'b0, MASTER_SRC_OSC = 1'b1, AUX_ENABLE = 1'b0;
  logic        AUX_SRC_OSC = 1'b1;
  logic [2:0]  xt_cnt = 3'h0;
  wire  [7:0]  REG_RDATA;
  wire         REG_RVALID, MASTER_CLK_O, MASTER_CLK_OE_N, AUX_CLOCK_PIN, TX_CLOCK;
  wire         OSC_REF_CLOCK, AUTO_MODE, SYNTH_RUNNING;
  int          n_errors = 0, check_count = 0;
  opllcc_top dut_u (.CLOCK(CLOCK), .RESET(RESET), .CRYSTAL_INPUT_PIN(CRYSTAL_INPUT_PIN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
    .RX_ENABLE(RX_ENABLE), .RX_STREAM(RX_STREAM), .RX_INT(RX_INT), .RX_FRAC(RX_FRAC),
    .RX_POST(RX_POST), .MASTER_IS_OUT(MASTER_IS_OUT), .MASTER_SRC_OSC(MASTER_SRC_OSC),
    .AUX_ENABLE(AUX_ENABLE), .AUX_SRC_OSC(AUX_SRC_OSC), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .MASTER_CLK_O(MASTER_CLK_O), .MASTER_CLK_OE_N(MASTER_CLK_OE_N),
    .AUX_CLOCK_PIN(AUX_CLOCK_PIN), .TX_CLOCK(TX_CLOCK), .OSC_REF_CLOCK(OSC_REF_CLOCK),
    .AUTO_MODE(AUTO_MODE), .SYNTH_RUNNING(SYNTH_RUNNING));
  always #2.5 CLOCK = !CLOCK;
  always @(posedge CLOCK) begin
    xt_cnt <= xt_cnt + 3'h1;
    if (xt_cnt == 3'h7) CRYSTAL_INPUT_PIN <= !CRYSTAL_INPUT_PIN;
  end
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    check_count++;
    if (g < e - 2 || g > e + 2) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1'b1;
    @(posedge CLOCK);
    REG_WE <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RE <= 1'b1;
    @(posedge CLOCK);
    REG_RE <= 1'b0;
    @(negedge CLOCK);
    chk_byte(REG_RDATA, e);
  endtask
  // counts rising edges over 16 oscillator periods
  task automatic meas(input int e_tx, input int e_pin);
    int   k, n_tx, n_mc, n_ax, guard;
    logic p_os, p_tx, p_mc, p_ax;
    k = 0;
    n_tx = 0;
    n_mc = 0;
    n_ax = 0;
    guard = 0;
    repeat (40) @(negedge CLOCK);
    {p_os, p_tx, p_mc, p_ax} = {OSC_REF_CLOCK, TX_CLOCK, MASTER_CLK_O, AUX_CLOCK_PIN};
    while (k < 17 && guard < 1000) begin
      @(negedge CLOCK);
      guard++;
      if (OSC_REF_CLOCK && !p_os) k++;
      if (k > 0 && k < 17) begin
        n_tx += int'(TX_CLOCK && !p_tx);
        n_mc += int'(MASTER_CLK_O && !p_mc);
        n_ax += int'(AUX_CLOCK_PIN && !p_ax);
      end
      {p_os, p_tx, p_mc, p_ax} = {OSC_REF_CLOCK, TX_CLOCK, MASTER_CLK_O, AUX_CLOCK_PIN};
    end
    chk_cnt(n_tx, e_tx);
    chk_cnt(n_mc, e_pin);
    chk_cnt(n_ax, e_pin);
  endtask
  task automatic osc_seen(input logic e);
    logic s;
    s = 1'b0;
    repeat (64) begin
      @(negedge CLOCK);
      s = s | OSC_REF_CLOCK;
    end
    chk_byte({7'h00, s}, {7'h00, e});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_vals;
    rd(7'h03, 8'h21);
    rd(7'h04, 8'hfd);
    rd(7'h05, 8'h36);
    rd(7'h06, 8'h07);
    rd(7'h07, 8'h06);
    rd(7'h00, 8'h00);
  endtask
  task automatic t_power;
    osc_seen(1'b0);
    wr(7'h1e, 8'h07);
    osc_seen(1'b1);
    chk_byte({7'h00, SYNTH_RUNNING}, 8'h00);
    wr(7'h1e, 8'h06);
    rd(7'h1e, 8'h06);
    chk_byte({7'h00, SYNTH_RUNNING}, 8'h01);
    wr(7'h1e, 8'h0e);
    rd(7'h1e, 8'h0e);
    chk_byte({7'h00, SYNTH_RUNNING}, 8'h00);
    wr(7'h1e, 8'h06);
  endtask
  task automatic t_manual;
    @(posedge CLOCK);
    MASTER_IS_OUT <= 1'b1;
    AUX_ENABLE <= 1'b1;
    wr(7'h03, 8'h00);
    wr(7'h04, 8'h00);
    wr(7'h05, 8'h00);
    wr(7'h06, 8'h08);
    wr(7'h07, 8'h04);
    meas(64, 16);
    chk_byte({7'h00, MASTER_CLK_OE_N}, 8'h00);
    wr(7'h05, 8'h30);
    rd(7'h05, 8'h30);
    meas(70, 16);
    wr(7'h07, 8'h00);
    meas(64, 16);
    @(posedge CLOCK);
    MASTER_SRC_OSC <= 1'b0;
    AUX_SRC_OSC <= 1'b0;
    meas(64, 64);
    @(posedge CLOCK);
    MASTER_SRC_OSC <= 1'b1;
    AUX_SRC_OSC <= 1'b1;
    wr(7'h06, 8'h18);
    wr(7'h07, 8'h01);
    rd(7'h06, 8'h18);
    meas(16, 16);
  endtask
  task automatic t_auto;
    @(posedge CLOCK);
    RESET <= 1'b1;
    RX_ENABLE <= 1'b1;
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    wr(7'h1e, 8'h06);
    meas(32, 16);
    chk_byte({7'h00, AUTO_MODE}, 8'h01);
    @(posedge CLOCK);
    RX_STREAM <= 1'b1;
    meas(8, 16);
    wr(7'h07, 8'h04);
    rd(7'h07, 8'h07);
    @(posedge CLOCK);
    RX_STREAM <= 1'b0;
    RX_INT <= 4'hc;
    RX_POST <= 2'h0;
    meas(8, 16);
    @(posedge CLOCK);
    RX_ENABLE <= 1'b0;
    repeat (3) @(negedge CLOCK);
    chk_byte({7'h00, AUTO_MODE}, 8'h00);
  endtask
  task automatic finish_test;
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge CLOCK);
    RESET <= 1'b0;
    t_reset_vals;
    t_power;
    t_manual;
    t_auto;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_errors++;
    finish_test;
  end
endmodule // opllcc_top_tb
`default_nettype wire
